//--- verilog/fpe_consts.svh
/*
 * Constants for the flash program/erase sequencer: APB register offsets,
 * field positions and wait times with a macro that turns microseconds into cycle counts.
 * Assumes a 25 MHz pclk; the includer supplies nothing else.
 */
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH

`define FPE_CLK_MHZ 25
`define FPE_US(t) ((t) * `FPE_CLK_MHZ)

`define FPE_OFF_CTRL 12'h000
`define FPE_OFF_ADDR 12'h004
`define FPE_OFF_STATUS 12'h008
`define FPE_OFF_PASSES 12'h00C

`define FPE_CTRL_START 0
`define FPE_CTRL_ERASE 1
`define FPE_CTRL_LONG_EPULSE 2
`define FPE_ST_BUSY 0
`define FPE_ST_DONE 1
`define FPE_ST_FAIL 2

`define FPE_T_WEN_US 10
`define FPE_T_PSET_US 50
`define FPE_T_PSHORT_US 150
`define FPE_T_PLONG_US 500
`define FPE_T_PCLR_US 10
`define FPE_T_PSETCLR_US 10
`define FPE_T_PVFY_US 4
`define FPE_T_DUMMY_US 2
`define FPE_T_PVFYCLR_US 4
`define FPE_T_ESET_US 200
`define FPE_T_ESHORT_MS 5
`define FPE_T_ELONG_MS 10
`define FPE_T_ECLR_US 10
`define FPE_T_ESETCLR_US 10
`define FPE_T_EVFY_US 20
`define FPE_T_EVFYCLR_US 5

`define FPE_PROG_PASS_MAX 403
`define FPE_SHORT_PASSES 4
`define FPE_ERASE_PASS_SHORT 240
`define FPE_ERASE_PASS_LONG 120
`define FPE_UNIT_BYTES 32
`define FPE_ALL_ONES 8'hFF

`endif

//--- verilog/fpe_pkg.sv
/*
 * Types for the flash program/erase sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpe_pkg;
    typedef enum logic [4:0] {
        FPE_IDLE, FPE_WEN, FPE_SETUP, FPE_PULSE, FPE_PCLR, FPE_SUCLR,
        FPE_VFY, FPE_DWR, FPE_DWAIT, FPE_RD, FPE_RWAIT, FPE_CMP,
        FPE_VCLR, FPE_WENOFF, FPE_END
    } fpe_state_t;
endpackage

//--- verilog/fpe_seq.sv
/*
 * Host-side sequencer that drives the flash control bits of an on-chip
 * flash through program/verify and erase/verify loops with counted waits.
 * Software starts it over APB. Assumes the flash answers reads on the
 * cycle after mem_rd and that the flash takes each control bit as a level.
 */
`timescale 1ns/1ps
`include "fpe_consts.svh"

module fpe_seq #(
    parameter int UNIT = `FPE_UNIT_BYTES,
    parameter int PROG_MAX = `FPE_PROG_PASS_MAX,
    parameter int ELONG_CYC = `FPE_US(`FPE_T_ELONG_MS * 1000),
    parameter int ESHORT_CYC = `FPE_US(`FPE_T_ESHORT_MS * 1000)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flash_write_enable_bit,
    output logic program_setup_bit,
    output logic program_pulse_bit,
    output logic program_verify_bit,
    output logic erase_setup_bit,
    output logic erase_pulse_bit,
    output logic erase_verify_bit,
    output logic [31:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_wr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata
);
    import fpe_pkg::*;

    localparam int CW = 24;

    fpe_state_t state;
    logic [CW-1:0] wait_cnt;
    logic [8:0] pass_cnt;
    logic [5:0] byte_idx;
    logic erase_mode;
    logic long_epulse;
    logic all_ok;
    logic [31:0] base_addr;
    logic fail;
    logic done;
    logic [7:0] read_byte;

    wire wr_acc = psel && penable && pwrite;
    wire start = wr_acc && paddr == `FPE_OFF_CTRL && pwdata[`FPE_CTRL_START] && state == FPE_IDLE;
    wire wait_done = wait_cnt == '0;

    function automatic logic [CW-1:0] cyc(input int n);
        cyc = CW'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave; always ready, unmapped reads return zero with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `FPE_OFF_CTRL: prdata <= {29'h0, long_epulse, erase_mode, 1'b0};
                    `FPE_OFF_ADDR: prdata <= base_addr;
                    `FPE_OFF_STATUS: prdata <= {29'h0, fail, done, state != FPE_IDLE};
                    `FPE_OFF_PASSES: prdata <= {23'h0, pass_cnt};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_addr <= 32'h0000_0000;
            erase_mode <= 1'b0;
            long_epulse <= 1'b0;
        end else if (wr_acc && state == FPE_IDLE) begin
            if (paddr == `FPE_OFF_ADDR) begin
                base_addr <= pwdata;
            end
            if (paddr == `FPE_OFF_CTRL) begin
                erase_mode <= pwdata[`FPE_CTRL_ERASE];
                long_epulse <= pwdata[`FPE_CTRL_LONG_EPULSE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; the pulse wait is exactly the count so it is both min and max
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= FPE_IDLE;
            wait_cnt <= '0;
            pass_cnt <= 9'h000;
            byte_idx <= 6'h00;
            all_ok <= 1'b0;
            fail <= 1'b0;
            done <= 1'b0;
            read_byte <= 8'h00;
            flash_write_enable_bit <= 1'b0;
            program_setup_bit <= 1'b0;
            program_pulse_bit <= 1'b0;
            program_verify_bit <= 1'b0;
            erase_setup_bit <= 1'b0;
            erase_pulse_bit <= 1'b0;
            erase_verify_bit <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 8'h00;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            if (!wait_done) begin
                wait_cnt <= wait_cnt - 1'b1;
            end
            case (state)
                FPE_IDLE: begin
                    if (start) begin
                        done <= 1'b0;
                        fail <= 1'b0;
                        pass_cnt <= 9'h000;
                        flash_write_enable_bit <= 1'b1;
                        wait_cnt <= cyc(`FPE_US(`FPE_T_WEN_US));
                        state <= FPE_WEN;
                    end
                end
                FPE_WEN: begin
                    if (wait_done) begin
                        pass_cnt <= pass_cnt + 1'b1;
                        if (erase_mode) begin
                            erase_setup_bit <= 1'b1;
                            wait_cnt <= cyc(`FPE_US(`FPE_T_ESET_US));
                        end else begin
                            program_setup_bit <= 1'b1;
                            wait_cnt <= cyc(`FPE_US(`FPE_T_PSET_US));
                        end
                        state <= FPE_SETUP;
                    end
                end
                FPE_SETUP: begin
                    if (wait_done) begin
                        if (erase_mode) begin
                            erase_pulse_bit <= 1'b1;
                            wait_cnt <= cyc(long_epulse ? ELONG_CYC : ESHORT_CYC);
                        end else begin
                            program_pulse_bit <= 1'b1;
                            if (pass_cnt <= 9'(`FPE_SHORT_PASSES)) begin
                                wait_cnt <= cyc(`FPE_US(`FPE_T_PSHORT_US));
                            end else begin
                                wait_cnt <= cyc(`FPE_US(`FPE_T_PLONG_US));
                            end
                        end
                        state <= FPE_PULSE;
                    end
                end
                FPE_PULSE: begin
                    if (wait_done) begin
                        program_pulse_bit <= 1'b0;
                        erase_pulse_bit <= 1'b0;
                        wait_cnt <= cyc(`FPE_US(erase_mode ? `FPE_T_ECLR_US : `FPE_T_PCLR_US));
                        state <= FPE_PCLR;
                    end
                end
                FPE_PCLR: begin
                    if (wait_done) begin
                        program_setup_bit <= 1'b0;
                        erase_setup_bit <= 1'b0;
                        wait_cnt <= cyc(`FPE_US(erase_mode ? `FPE_T_ESETCLR_US : `FPE_T_PSETCLR_US));
                        state <= FPE_SUCLR;
                    end
                end
                FPE_SUCLR: begin
                    if (wait_done) begin
                        program_verify_bit <= !erase_mode;
                        erase_verify_bit <= erase_mode;
                        wait_cnt <= cyc(`FPE_US(erase_mode ? `FPE_T_EVFY_US : `FPE_T_PVFY_US));
                        byte_idx <= 6'h00;
                        all_ok <= 1'b1;
                        state <= FPE_VFY;
                    end
                end
                FPE_VFY: begin
                    if (wait_done) begin
                        state <= FPE_DWR;
                    end
                end
                FPE_DWR: begin
                    mem_addr <= base_addr + 32'(byte_idx);
                    mem_wdata <= `FPE_ALL_ONES;
                    mem_wr <= 1'b1;
                    wait_cnt <= cyc(`FPE_US(`FPE_T_DUMMY_US));
                    state <= FPE_DWAIT;
                end
                FPE_DWAIT: begin
                    if (wait_done) begin
                        mem_rd <= 1'b1;
                        state <= FPE_RD;
                    end
                end
                FPE_RD: begin
                    state <= FPE_RWAIT;
                end
                FPE_RWAIT: begin
                    read_byte <= mem_rdata;
                    state <= FPE_CMP;
                end
                FPE_CMP: begin
                    // Compare against all-ones in erase mode only; programmed-data checking is left to software
                    if (read_byte != `FPE_ALL_ONES && erase_mode) begin
                        all_ok <= 1'b0;
                    end
                    if (32'(byte_idx) == 32'(UNIT - 1)) begin
                        program_verify_bit <= 1'b0;
                        erase_verify_bit <= 1'b0;
                        wait_cnt <= cyc(`FPE_US(erase_mode ? `FPE_T_EVFYCLR_US : `FPE_T_PVFYCLR_US));
                        state <= FPE_VCLR;
                    end else begin
                        byte_idx <= byte_idx + 1'b1;
                        state <= FPE_DWR;
                    end
                end
                FPE_VCLR: begin
                    if (wait_done) begin
                        if (all_ok) begin
                            state <= FPE_WENOFF;
                        end else if (erase_mode ? pass_cnt >= 9'(long_epulse ? `FPE_ERASE_PASS_LONG
                                                    : `FPE_ERASE_PASS_SHORT)
                                   : pass_cnt >= 9'(PROG_MAX)) begin
                            fail <= 1'b1;
                            state <= FPE_WENOFF;
                        end else begin
                            state <= FPE_WEN;
                        end
                    end
                end
                FPE_WENOFF: begin
                    flash_write_enable_bit <= 1'b0;
                    state <= FPE_END;
                end
                FPE_END: begin
                    done <= 1'b1;
                    state <= FPE_IDLE;
                end
                default: state <= FPE_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    int wen_age;
    logic [CW-1:0] pulse_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wen_age <= 0;
        end else begin
            wen_age <= flash_write_enable_bit ? wen_age + 1 : 0;
        end
    end

    // Pulse length kept in a counter; a delay range thousands of cycles long would choke the tools
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_len <= '0;
        end else begin
            pulse_len <= program_pulse_bit ? pulse_len + 1'b1 : '0;
        end
    end

    sequence setup_rise_s;
        $rose(program_setup_bit) || $rose(erase_setup_bit);
    endsequence

    wen_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rise_s |-> wen_age >= `FPE_US(`FPE_T_WEN_US))
        else $error("setup set too soon after write enable");
    prog_setup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(program_setup_bit) |-> !program_pulse_bit [*8])
        else $error("program pulse too soon after setup");
    pulse_short_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(program_pulse_bit) && pass_cnt <= 9'h004 |-> pulse_len == CW'(`FPE_US(`FPE_T_PSHORT_US)))
        else $error("short program pulse out of range");
    pulse_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(program_pulse_bit) |-> program_setup_bit [*8])
        else $error("setup cleared too soon after pulse");
    pass_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        !erase_mode |-> pass_cnt <= 9'(PROG_MAX))
        else $error("program pass count over limit");
    dummy_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
        mem_wr |-> mem_wdata == 8'hFF && (program_verify_bit || erase_verify_bit) ##1 !mem_rd [*8])
        else $error("dummy write wrong or read too soon");
    erase_vfy_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(erase_verify_bit) |-> !mem_wr [*8])
        else $error("erase dummy write too soon");
    order_a: assert property (@(posedge pclk) disable iff (!presetn)
        (program_pulse_bit |-> program_setup_bit && flash_write_enable_bit)
        and (erase_pulse_bit |-> erase_setup_bit && flash_write_enable_bit))
        else $error("pulse without setup and enable");
endmodule

//--- verif/fpe_flash_model.sv
/*
 * Behavioural model of the on-chip flash seen by the sequencer: it watches
 * the control bits, times every step in pclk cycles and answers verify reads.
 * Assumes 25 MHz pclk and the sequencer's one-cycle mem_wr and mem_rd pulses.
 */
`timescale 1ns/1ps
module fpe_flash_model #(
    parameter int PMAX = 5,
    parameter int ESHORT = 20,
    parameter int ELONG = 40,
    parameter int NEED = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic long_mode,
    input wire logic flash_write_enable_bit,
    input wire logic program_setup_bit,
    input wire logic program_pulse_bit,
    input wire logic program_verify_bit,
    input wire logic erase_setup_bit,
    input wire logic erase_pulse_bit,
    input wire logic erase_verify_bit,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    output int fault_count
);
    logic [6:0] q;
    logic [6:0] b;
    int cyc, t_ev, need, npass, epass, idx, width;
    longint psum, esum;
    ////////////////////////////////////////////////////////////////////////
    task automatic flag(input string what, input int exp, input int seen);
        fault_count++;
        $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    endtask
    // Each step must keep the minimum gap set up by the step before it
    task automatic step(input int nd);
        if (cyc - t_ev < need) flag("gap between flash steps", need, cyc - t_ev);
        t_ev = cyc;
        need = nd;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        b = {flash_write_enable_bit, program_setup_bit, program_pulse_bit, program_verify_bit,
             erase_setup_bit, erase_pulse_bit, erase_verify_bit};
        if (!presetn) begin
            q = '0;
            cyc = 0;
            t_ev = 0;
            need = 0;
            fault_count = 0;
        end else begin
            cyc++;
            if (b[6] && !q[6]) begin
                step(250);
                npass = 0;
                epass = 0;
                psum = 0;
                esum = 0;
            end
            if (b[5] && !q[5]) begin
                step(1250);
                npass++;
                if (npass > PMAX) flag("program passes", PMAX, npass);
            end
            if (b[2] && !q[2]) begin
                step(5000);
                epass++;
                if (epass > (long_mode ? 120 : 240)) flag("erase passes", long_mode ? 120 : 240, epass);
            end
            if (b[4] && !q[4]) step(0);
            if (b[1] && !q[1]) step(0);
            if (!b[4] && q[4]) begin
                width = cyc - t_ev;
                psum += width;
                if (width != (npass <= 4 ? 3750 : 12500)) flag("program pulse", npass <= 4 ? 3750 : 12500, width);
                if (psum > 5000000) flag("program pulse total", 5000000, width);
                step(250);
            end
            if (!b[1] && q[1]) begin
                width = cyc - t_ev;
                esum += width;
                if (width != (long_mode ? ELONG : ESHORT)) flag("erase pulse", long_mode ? ELONG : ESHORT, width);
                if (esum > 30000000) flag("erase pulse total", 30000000, width);
                step(250);
            end
            if ((!b[5] && q[5]) || (!b[2] && q[2])) step(250);
            if (b[3] && !q[3]) step(100);
            if (b[0] && !q[0]) step(500);
            if (b[3] || b[0]) begin
                if (b[3] == q[3] && b[0] == q[0] && !(q[3] || q[0])) idx = 0;
            end else begin
                idx = 0;
            end
            if (mem_wr) begin
                step(50);
                if (mem_wdata !== 8'hFF) flag("dummy write data", 8'hFF, mem_wdata);
                if (mem_addr[4:0] !== idx[4:0]) flag("verify address", idx, mem_addr[4:0]);
                idx++;
            end
            if (mem_rd) step(0);
            if (!b[3] && q[3]) step(100);
            if (!b[0] && q[0]) step(125);
            if (!b[6] && q[6]) step(0);
            // Pulse only under its setup, setups only under write enable, verify only with setup clear
            if ((b[4] && !b[5]) || (b[1] && !b[2]) || ((b[5] || b[2] || b[3] || b[0]) && !b[6])
                || (b[3] && b[5]) || (b[0] && b[2]) || ((mem_wr || mem_rd) && !(b[3] || b[0])))
                flag("control bit order", 0, b);
            q = b;
        end
    end
    // Outside a read the data lines toggle every cycle so stale data cannot pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) mem_rdata <= 8'h5A;
        else if (mem_rd) mem_rdata <= (erase_verify_bit && epass >= NEED) ? 8'hFF : 8'h00;
        else mem_rdata <= ~mem_rdata;
    end
endmodule

//--- verif/flash_program_erase_timing_tb.sv
/*
 * Self-checking bench for the flash program/erase sequencer over APB.
 * Assumes the flash model in fpe_flash_model.sv and shortened erase counts.
 */
`timescale 1ns/1ps
module flash_program_erase_timing_tb;
    logic pclk, presetn, psel, penable, pwrite, long_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, serr, we, ps, pp, pvfy, es, ep, evfy, mem_wr, mem_rd;
    logic [31:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    int fault_count;
    int err_count = 0;
    int total_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    fpe_seq #(.PROG_MAX(5), .ELONG_CYC(40), .ESHORT_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_write_enable_bit(we), .program_setup_bit(ps), .program_pulse_bit(pp),
        .program_verify_bit(pvfy), .erase_setup_bit(es), .erase_pulse_bit(ep), .erase_verify_bit(evfy),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    // Model defaults already match the shortened counts given to the sequencer above
    fpe_flash_model flash (.pclk(pclk), .presetn(presetn),
        .long_mode(long_mode), .flash_write_enable_bit(we), .program_setup_bit(ps), .program_pulse_bit(pp),
        .program_verify_bit(pvfy), .erase_setup_bit(es), .erase_pulse_bit(ep), .erase_verify_bit(evfy),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .fault_count(fault_count));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed here; a slave that never answers is caught by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 30000);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        apb(1'b0, 12'h008, 32'h0);
        check("status after reset", 32'h0, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check("passes after reset", 32'h0, rd);
        check("control bits after reset", 32'h0, {we, ps, pp, pvfy, es, ep, evfy});
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read data", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, serr});
    endtask
    task automatic test_program();
        apb(1'b1, 12'h004, 32'h00001000);
        apb(1'b1, 12'h000, 32'h00000001);
        apb(1'b0, 12'h008, 32'h0);
        check("busy after start", 32'h1, rd);
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b1, 12'h004, 32'h00002000);
        wait_done();
        check("program status", 32'h2, rd);
        apb(1'b0, 12'h004, 32'h0);
        check("address kept while busy", 32'h00001000, rd);
        apb(1'b0, 12'h000, 32'h0);
        check("control kept while busy", 32'h0, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check("program passes", 32'h1, rd);
        check("flash faults", 32'h0, fault_count);
    endtask
    task automatic test_erase(input logic lng);
        long_mode <= lng;
        apb(1'b1, 12'h000, {29'h0, lng, 2'b11});
        wait_done();
        check("erase status", 32'h2, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check("erase passes", 32'h3, rd);
        apb(1'b0, 12'h000, 32'h0);
        check("erase control", {29'h0, lng, 2'b10}, rd);
        check("flash faults", 32'h0, fault_count);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        long_mode = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_program();
        test_erase(1'b0);
        test_erase(1'b1);
        give_verdict();
    end
    // Whole run is near 60k cycles; 100k cycles means a hang
    initial begin
        #4000000;
        err_count++;
        give_verdict();
    end
endmodule
